// file: acs_defines.svh
// Register offsets, field positions, reset values and timing figures of the
// conversion sequencer. Assumes inclusion by its bare name.
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_CFG 8'h04
`define ACS_OFF_RESULT 8'h08
`define ACS_OFF_RES_HI 8'h0C
`define ACS_OFF_RES_LO 8'h10
`define ACS_OFF_STATUS 8'h14
`define ACS_OFF_IRQ_STAT 8'h18
`define ACS_OFF_IRQ_EN 8'h1C
`define ACS_OFF_IRQ_CLR 8'h20
`define ACS_CTRL_CONT 0
`define ACS_CTRL_START 1
`define ACS_CTRL_DEF 2
`define ACS_CTRL_CONV_EN 3
`define ACS_CTRL_AMP_LSB 4
`define ACS_CTRL_AMP_MSB 7
`define ACS_CTRL_RST 8'h00
`define ACS_CFG_OSR_LSB 0
`define ACS_CFG_OSR_MSB 2
`define ACS_CFG_NEL_LSB 3
`define ACS_CFG_NEL_MSB 4
`define ACS_CFG_FS_LSB 5
`define ACS_CFG_FS_MSB 6
`define ACS_CFG_CBIAS_LSB 7
`define ACS_CFG_CBIAS_MSB 8
`define ACS_CFG_ABIAS_LSB 9
`define ACS_CFG_ABIAS_MSB 10
`define ACS_CFG_RST 11'h000
`define ACS_IRQ_DONE 0
`define ACS_IRQ_OVER 1
`define ACS_IRQ_UNDER 2
`define ACS_IRQ_RST 3'h0
`define ACS_RESULT_RST 16'h0000
`define ACS_SAT_POS 16'h7FFF
`define ACS_SAT_NEG 16'h8000
`define ACS_OSC_HZ 4000000
`define ACS_OSC_DIV_SLOWEST 64
`define ACS_OSR_EXP_BASE 3
`define ACS_RES_BASE 5'h06
`define ACS_RES_FULL 5'h10
`endif

// file: acs_pkg.sv
// Types shared by the conversion sequencer and its environment.
// Assumes acs_defines.svh holds the numeric constants.
package acs_pkg;
  typedef logic [1:0] acs_bias_t;
  typedef logic [3:0] acs_amp_en_t;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_ELEM = 2'b01,
    ACS_QUANT = 2'b11,
    ACS_STORE = 2'b10
  } acs_state_e;
endpackage

// file: acs_adc_sequencer.sv
// Conversion sequencer of an incremental over-sampling converter, APB slave.
// Assumes the analog chain presents raw_code_i while quantize_o is high.
`timescale 1ns/1ns
`include "acs_defines.svh"
module acs_adc_sequencer #(
  parameter int CLK_HZ = 100000000,
  parameter int RAW_W = 18
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic signed [RAW_W-1:0] raw_code_i,
  output logic sample_tick_o,
  output logic offset_polarity_o,
  output logic quantize_o,
  output logic done_o,
  output logic busy_o,
  output logic conv_enable_o,
  output acs_pkg::acs_amp_en_t amp_enable_o,
  output acs_pkg::acs_bias_t converter_bias_select_o,
  output acs_pkg::acs_bias_t amplifier_bias_select_o
);
  import acs_pkg::*;

  // One oscillator period in system clocks; slowest rate divides it further
  localparam int OSC_DIV = CLK_HZ / `ACS_OSC_HZ;
  localparam int DIV_BASE = OSC_DIV * `ACS_OSC_DIV_SLOWEST;
  localparam int DIV_W = $clog2(DIV_BASE + 1);

  if (CLK_HZ % `ACS_OSC_HZ != 0 || OSC_DIV < 1 || RAW_W < 17) begin : g_chk
    $error("acs_adc_sequencer: unsupported CLK_HZ or RAW_W");
  end

  // Register file
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [10:0] cfg_ff, nxt_cfg;
  logic [2:0] irq_en_ff, nxt_irq_en;
  logic [2:0] irq_stat_ff, nxt_irq_stat;
  logic irq_ff, nxt_irq;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic start_req_ff, nxt_start_req;
  // Sequencer
  acs_state_e state_ff, nxt_state;
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;
  logic [10:0] samp_ff, nxt_samp;
  logic [2:0] elem_ff, nxt_elem;
  logic pol_ff, nxt_pol;
  logic quant_ff, nxt_quant;
  logic done_ff, nxt_done;
  logic busy_ff, nxt_busy;
  logic [15:0] result_ff, nxt_result;

  logic [2:0] osr_sel;
  logic [1:0] nel_sel;
  logic [1:0] fs_sel;
  logic cont_mode;
  logic conv_en;
  logic [10:0] osr_last;
  logic [2:0] nel_last;
  logic [DIV_W-1:0] div_load;
  logic [4:0] res_bits;
  logic [4:0] forced_n;
  logic over_rng, under_rng;
  logic [15:0] sat_code;
  logic [15:0] fmt_code;
  logic [2:0] events;
  logic acc_phase, wr_en, addr_hit;
  logic [31:0] rd_mux;

  assign osr_sel = cfg_ff[`ACS_CFG_OSR_MSB:`ACS_CFG_OSR_LSB];
  assign nel_sel = cfg_ff[`ACS_CFG_NEL_MSB:`ACS_CFG_NEL_LSB];
  assign fs_sel = cfg_ff[`ACS_CFG_FS_MSB:`ACS_CFG_FS_LSB];
  assign cont_mode = ctrl_ff[`ACS_CTRL_CONT];
  assign conv_en = ctrl_ff[`ACS_CTRL_CONV_EN];
  // OSR = 2^(3+code) counted 0..OSR, so OSR+1 periods per elementary conversion
  assign osr_last = 11'(11'h001 << (`ACS_OSR_EXP_BASE + osr_sel));
  assign nel_last = 3'((4'h1 << nel_sel) - 4'h1);
  assign div_load = DIV_W'((DIV_BASE >> fs_sel) - 1);

  // Output formatting: clamp, then force insignificant bits to 1 followed by 0s
  assign over_rng = raw_code_i > RAW_W'(signed'(`ACS_SAT_POS));
  assign under_rng = raw_code_i < -RAW_W'(signed'({1'b0, `ACS_SAT_NEG}));
  always_comb begin
    sat_code = raw_code_i[15:0];
    if (over_rng) begin
      sat_code = `ACS_SAT_POS;
    end else if (under_rng) begin
      sat_code = `ACS_SAT_NEG;
    end
  end
  assign res_bits = `ACS_RES_BASE + {1'b0, osr_sel, 1'b0} + {3'h0, nel_sel};
  assign forced_n = (res_bits < `ACS_RES_FULL) ? (`ACS_RES_FULL - res_bits) : 5'h00;
  for (genvar i = 0; i < 16; i++) begin : g_fmt
    assign fmt_code[i] = (5'(i) < forced_n) ? (5'(i) == forced_n - 5'h01) : sat_code[i];
  end

  // Sample-rate divider, runs only while a conversion is in flight
  always_comb begin
    nxt_div = div_load;
    nxt_tick = 1'b0;
    // No tick on the abort edge, so a tick never shows while idle
    if (state_ff != ACS_IDLE && conv_en) begin
      if (div_ff == '0) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_div = div_ff - DIV_W'(1);
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  // Conversion sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_samp = samp_ff;
    nxt_elem = elem_ff;
    nxt_pol = pol_ff;
    nxt_quant = 1'b0;
    nxt_done = 1'b0;
    nxt_result = result_ff;
    events = 3'h0;
    unique case (state_ff)
      ACS_IDLE: begin
        if (start_req_ff && conv_en) begin
          nxt_state = ACS_ELEM;
          nxt_samp = '0;
          nxt_elem = '0;
          nxt_pol = 1'b0;
        end
      end
      ACS_ELEM: begin
        if (tick_ff) begin
          if (samp_ff == osr_last) begin
            nxt_samp = '0;
            nxt_pol = ~pol_ff;
            if (elem_ff == nel_last) begin
              nxt_state = ACS_QUANT;
            end else begin
              nxt_elem = elem_ff + 3'h1;
            end
          end else begin
            nxt_samp = samp_ff + 11'h001;
          end
        end
      end
      ACS_QUANT: begin
        if (tick_ff) begin
          nxt_quant = 1'b1;
          nxt_state = ACS_STORE;
        end
      end
      ACS_STORE: begin
        // Whole word written in one edge so both bytes always match
        nxt_result = fmt_code;
        nxt_done = 1'b1;
        events[`ACS_IRQ_DONE] = 1'b1;
        events[`ACS_IRQ_OVER] = over_rng;
        events[`ACS_IRQ_UNDER] = under_rng;
        nxt_samp = '0;
        nxt_elem = '0;
        nxt_pol = 1'b0;
        nxt_state = cont_mode ? ACS_ELEM : ACS_IDLE;
      end
    endcase
    if (!conv_en) begin
      nxt_state = ACS_IDLE;
      nxt_quant = 1'b0;
    end
    nxt_busy = nxt_state != ACS_IDLE;
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_ff <= ACS_IDLE;
      samp_ff <= '0;
      elem_ff <= '0;
      pol_ff <= 1'b0;
      quant_ff <= 1'b0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
      result_ff <= `ACS_RESULT_RST;
    end else begin
      state_ff <= nxt_state;
      samp_ff <= nxt_samp;
      elem_ff <= nxt_elem;
      pol_ff <= nxt_pol;
      quant_ff <= nxt_quant;
      done_ff <= nxt_done;
      busy_ff <= nxt_busy;
      result_ff <= nxt_result;
    end
  end

  // APB slave: one wait state, so pready and read data come from flops
  assign acc_phase = psel_i && penable_i && !pready_ff;
  assign wr_en = psel_i && penable_i && pready_ff && pwrite_i && !pslverr_ff;
  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      `ACS_OFF_CTRL: rd_mux[7:0] = ctrl_ff;
      `ACS_OFF_CFG: rd_mux[10:0] = cfg_ff;
      `ACS_OFF_RESULT: rd_mux[15:0] = result_ff;
      `ACS_OFF_RES_HI: rd_mux[7:0] = result_ff[15:8];
      `ACS_OFF_RES_LO: rd_mux[7:0] = result_ff[7:0];
      `ACS_OFF_STATUS: rd_mux[1:0] = {pol_ff, busy_ff};
      `ACS_OFF_IRQ_STAT: rd_mux[2:0] = irq_stat_ff;
      `ACS_OFF_IRQ_EN: rd_mux[2:0] = irq_en_ff;
      `ACS_OFF_IRQ_CLR: rd_mux = 32'h0000_0000;
      default: addr_hit = 1'b0;
    endcase
  end
  always_comb begin
    nxt_pready = acc_phase;
    nxt_pslverr = acc_phase && !addr_hit;
    nxt_prdata = acc_phase ? rd_mux : prdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_cfg = cfg_ff;
    nxt_irq_en = irq_en_ff;
    nxt_start_req = 1'b0;
    nxt_irq_stat = irq_stat_ff;
    if (wr_en) begin
      unique case (paddr_i)
        `ACS_OFF_CTRL: begin
          // Start and default bits act once and read back as zero
          nxt_ctrl = pwdata_i[7:0];
          nxt_ctrl[`ACS_CTRL_START] = 1'b0;
          nxt_ctrl[`ACS_CTRL_DEF] = 1'b0;
          nxt_start_req = pwdata_i[`ACS_CTRL_START] || pwdata_i[`ACS_CTRL_DEF];
        end
        `ACS_OFF_CFG: nxt_cfg = pwdata_i[10:0];
        `ACS_OFF_IRQ_EN: nxt_irq_en = pwdata_i[2:0];
        `ACS_OFF_IRQ_CLR: nxt_irq_stat = irq_stat_ff & ~pwdata_i[2:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    // A new event wins over a clear in the same cycle
    nxt_irq_stat = nxt_irq_stat | events;
    nxt_irq = |(nxt_irq_stat & nxt_irq_en);
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      ctrl_ff <= `ACS_CTRL_RST;
      cfg_ff <= `ACS_CFG_RST;
      irq_en_ff <= `ACS_IRQ_RST;
      irq_stat_ff <= `ACS_IRQ_RST;
      irq_ff <= 1'b0;
      start_req_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      ctrl_ff <= nxt_ctrl;
      cfg_ff <= nxt_cfg;
      irq_en_ff <= nxt_irq_en;
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
      start_req_ff <= nxt_start_req;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign irq_o = irq_ff;
  assign sample_tick_o = tick_ff;
  assign offset_polarity_o = pol_ff;
  assign quantize_o = quant_ff;
  assign done_o = done_ff;
  assign busy_o = busy_ff;
  assign conv_enable_o = ctrl_ff[`ACS_CTRL_CONV_EN];
  assign amp_enable_o = ctrl_ff[`ACS_CTRL_AMP_MSB:`ACS_CTRL_AMP_LSB];
  assign converter_bias_select_o = cfg_ff[`ACS_CFG_CBIAS_MSB:`ACS_CFG_CBIAS_LSB];
  assign amplifier_bias_select_o = cfg_ff[`ACS_CFG_ABIAS_MSB:`ACS_CFG_ABIAS_LSB];
endmodule

// file: acs_seq_chk.sv
// Port assertions of the conversion sequencer.
// Assumes binding onto acs_adc_sequencer; one clock domain.
`timescale 1ns/1ns
module acs_seq_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic sample_tick_o,
  input wire logic offset_polarity_o,
  input wire logic quantize_o,
  input wire logic done_o,
  input wire logic busy_o,
  input wire logic conv_enable_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_wait; psel_i && penable_i && !pready_o; endsequence
  property p_apb_wait; s_setup ##1 s_wait |=> pready_o; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("no answer after wait");
  property p_err_ready; pslverr_o |-> pready_o; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_quant_done; quantize_o |=> done_o && !quantize_o; endproperty
  a_quant_done: assert property (p_quant_done) else $error("done late");
  property p_done_pulse; done_o |=> !done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_quant_busy; quantize_o |-> busy_o; endproperty
  a_quant_busy: assert property (p_quant_busy) else $error("quantize idle");
  property p_tick_busy; sample_tick_o |-> busy_o; endproperty
  a_tick_busy: assert property (p_tick_busy) else $error("tick idle");
  property p_tick_gap; sample_tick_o |=> !sample_tick_o [*8]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
  property p_pol_start; $rose(busy_o) |-> !offset_polarity_o; endproperty
  a_pol_start: assert property (p_pol_start) else $error("bad start polarity");
  property p_pol_step;
    $changed(offset_polarity_o) |-> $past(sample_tick_o) || done_o || $rose(busy_o);
  endproperty
  a_pol_step: assert property (p_pol_step) else $error("polarity off tick");
  property p_conv_off; !conv_enable_o [*3] |-> !busy_o; endproperty
  a_conv_off: assert property (p_conv_off) else $error("busy while off");
endmodule
bind acs_adc_sequencer acs_seq_chk acs_seq_chk_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .sample_tick_o(sample_tick_o), .offset_polarity_o(offset_polarity_o),
  .quantize_o(quantize_o), .done_o(done_o), .busy_o(busy_o),
  .conv_enable_o(conv_enable_o));

// file: acs_analog_model.sv
// Analog chain stand-in: presents a code only in the quantize cycle.
// Assumes the bench sets level_i before the conversion ends.
`timescale 1ns/1ns
module acs_analog_model (
  input wire logic clock_i,
  input wire logic quantize_i,
  input wire logic signed [17:0] level_i,
  output logic signed [17:0] raw_code_o
);
  logic churn = 1'b0;
  // Churns outside quantize so a late or early sample shows up
  always @(posedge clock_i) churn <= ~churn;
  assign raw_code_o = quantize_i ? level_i : {18{churn}};
endmodule

// file: tb_acs_adc_sequencer.sv
// Self-checking bench of the conversion sequencer over APB.
// Assumes the analog model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`include "acs_defines.svh"
module tb_acs_adc_sequencer;
  import acs_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, irq_o, sample_tick_o, offset_polarity_o;
  logic quantize_o, done_o, busy_o, conv_enable_o;
  logic signed [17:0] raw_code_i;
  logic signed [17:0] level = '0;
  acs_amp_en_t amp_enable_o;
  acs_bias_t converter_bias_select_o, amplifier_bias_select_o;
  int error_cnt = 0;
  int total_checks = 0;
  int ticks = 0;
  longint last = 0;
  longint gap = 0;
  logic [32:0] exp_q[$];
  acs_adc_sequencer #(.CLK_HZ(100000000), .RAW_W(18)) acs_adc_sequencer_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .raw_code_i(raw_code_i),
    .sample_tick_o(sample_tick_o), .offset_polarity_o(offset_polarity_o),
    .quantize_o(quantize_o), .done_o(done_o), .busy_o(busy_o),
    .conv_enable_o(conv_enable_o), .amp_enable_o(amp_enable_o),
    .converter_bias_select_o(converter_bias_select_o),
    .amplifier_bias_select_o(amplifier_bias_select_o));
  acs_analog_model acs_analog_model_i (.clock_i(clock_i), .quantize_i(quantize_o),
    .level_i(level), .raw_code_o(raw_code_i));
  initial forever #5 clock_i = ~clock_i;
  task automatic chk(input logic [32:0] got, input logic [32:0] e);
    total_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    exp_q.push_back(e);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    // Waits for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle edge so a following call never re-drives psel in this time step
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (done_o !== 1'b1 && n < 40000);
    if (n >= 40000) error_cnt++;
  endtask
  function automatic logic [15:0] ex(input int v, input int r, input int c);
    logic [15:0] o;
    int k;
    o = v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0];
    k = 10 - 2 * r - c;
    // Clamp first, then force the bits below the resolution
    if (k > 0) o = ((o >> k) << k) | (16'h0001 << (k - 1));
    return o;
  endfunction
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    if (psel_i && penable_i && pready_o === 1'b1) begin
      chk({pslverr_o, pwrite_i ? 32'h0 : prdata_o}, exp_q.pop_front());
    end
    if (sample_tick_o === 1'b1) begin
      ticks++;
      gap = $time - last;
      last = $time;
    end
  end
  initial begin
    #900000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    int r, c, v, rt;
    logic [15:0] e;
    void'($urandom(60));
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(`ACS_OFF_CTRL, 32'h0);
    rd(`ACS_OFF_RESULT, 32'h0);
    apb(1'b1, 8'h24, 32'h1, 33'h1_0000_0000);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      r = i & 1;
      c = (i >> 1) & 1;
      rt = i >= 4 ? 2 : 3;
      v = i == 4 ? 40000 : i == 5 ? -40000 : int'($urandom_range(65535)) - 32768;
      level <= v[17:0];
      // Full bias keeps either rate legal; only two amplifier stages on
      wr(`ACS_OFF_CFG, 32'h780 | (rt << 5) | (c << 3) | r);
      wr(`ACS_OFF_IRQ_EN, 32'h7);
      ticks = 0;
      wr(`ACS_OFF_CTRL, 32'h3A);
      wait_done();
      e = ex(v, r, c);
      chk(ticks, (1 << c) * ((8 << r) + 1) + 1);
      chk(gap, (1600 >> rt) * 10);
      chk({converter_bias_select_o, amplifier_bias_select_o, amp_enable_o}, 33'hF3);
      rd(`ACS_OFF_RESULT, e);
      rd(`ACS_OFF_RES_HI, e[15:8]);
      rd(`ACS_OFF_RES_LO, e[7:0]);
      rd(`ACS_OFF_IRQ_STAT, {v < -32768, v > 32767, 1'b1});
      chk({irq_o, busy_o}, 33'h2);
      wr(`ACS_OFF_IRQ_EN, 32'h0);
      repeat (2) @(posedge clock_i);
      chk(irq_o, 33'h0);
      wr(`ACS_OFF_IRQ_CLR, 32'h7);
      wr(`ACS_OFF_IRQ_EN, 32'h7);
      repeat (2) @(posedge clock_i);
      chk(irq_o, 33'h0);
      $display("single conversion test %0d done", i);
    end
    wr(`ACS_OFF_CFG, 32'h7E0);
    wr(`ACS_OFF_CTRL, 32'h0B);
    wait_done();
    wait_done();
    repeat (3) @(posedge clock_i);
    chk(busy_o, 33'h1);
    wr(`ACS_OFF_CTRL, 32'h08);
    wait_done();
    repeat (3) @(posedge clock_i);
    chk(busy_o, 33'h0);
    wr(`ACS_OFF_CTRL, 32'h0C);
    repeat (3) @(posedge clock_i);
    chk(busy_o, 33'h1);
    wr(`ACS_OFF_CTRL, 32'h00);
    repeat (3) @(posedge clock_i);
    chk({busy_o, conv_enable_o, amp_enable_o}, 33'h0);
    $display("repeating mode test done");
    print_verdict();
  end
endmodule
